// file: hdl/sdr_regs.vh
// Purpose: constants of the switch diagnostics readout block
// Assumes: APB byte addresses, 32-bit data, 40 MHz core clock
// Notes: definitions only, no logic
`ifndef SDR_REGS_VH
`define SDR_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SDR_ADDR_CFG0 8'h00
`define SDR_ADDR_CFG1 8'h04
`define SDR_ADDR_FMASK 8'h08
`define SDR_ADDR_STAT0 8'h0c
`define SDR_ADDR_STAT1 8'h10
`define SDR_ADDR_I0 8'h14
`define SDR_ADDR_I1 8'h18
`define SDR_ADDR_V0 8'h1c
`define SDR_ADDR_V1 8'h20
`define SDR_ADDR_T0 8'h24
`define SDR_ADDR_T1 8'h28
`define SDR_ADDR_VBB 8'h2c
`define SDR_ADDR_INT_STAT 8'h30
`define SDR_ADDR_INT_CLR 8'h34
`define SDR_ADDR_INT_EN 8'h38

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define SDR_CFG_W 6
`define SDR_CFG_RST 6'h00
`define SDR_CFG_OFF_OL 0
`define SDR_CFG_SVBB 1
`define SDR_CFG_OL_ON 2
`define SDR_CFG_X8 3
`define SDR_CFG_PU_LSB 4
`define SDR_CFG_PU_MSB 5
`define SDR_FMASK_RST 2'h0
`define SDR_STAT_OFF_OL 0
`define SDR_STAT_SHORT 1
`define SDR_STAT_RDY 2
`define SDR_RES_W 10
`define SDR_RES_RST 10'h000
`define SDR_RES_RDY_BIT 15
`define SDR_INT_W 6
`define SDR_INT_RST 6'h00
`define SDR_INT_OL_LSB 0
`define SDR_INT_SH_LSB 2
`define SDR_INT_RDY_LSB 4

// ----------------------------------------------------------------
// Converter sources and timing
// ----------------------------------------------------------------
`define SDR_SRC_W 3
`define SDR_SRC_NUM 7
`define SDR_SRC_I0 3'h0
`define SDR_SRC_LAST 3'h6
`define SDR_OL_ON_LIMIT_CODE 10'h014
`define SDR_CLK_MHZ 40
`define SDR_SVBB_SETTLE_NS 2000
`define SDR_SVBB_SETTLE_CYC ((`SDR_SVBB_SETTLE_NS * `SDR_CLK_MHZ + 999) / 1000)
`define SDR_CNT_W 8

`endif

// file: hdl/sdr_chan_diag.v
// Purpose: off-state open-load and short-to-battery check of one channel
// Assumes: comparator result is synchronous to the clock
// Notes: all outputs registered
`include "sdr_regs.vh"

module sdr_chan_diag (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Channel state and configuration
	input wire fet_on_i,
	input wire off_ol_en_i,
	input wire svbb_en_i,
	input wire cmp_above_i,
	// Drive and result
	output reg pullup_en_o,
	output reg pulldown_en_o,
	output reg off_ol_flag_o,
	output reg short_flag_o
);

	reg [`SDR_CNT_W-1:0] cnt_q;
	reg [`SDR_CNT_W-1:0] cnt_d;
	wire detect_on;
	wire settled;

	// ----------------------------------------------------------------
	// Detection window
	// ----------------------------------------------------------------
	assign detect_on = ~fet_on_i & off_ol_en_i;
	assign settled = (cnt_q == `SDR_SVBB_SETTLE_CYC);

	// Settle counter runs only while the pulldown is applied and the output stays high
	always @* begin
		cnt_d = {`SDR_CNT_W{1'b0}};
		if (pulldown_en_o && cmp_above_i) begin
			if (settled)
				cnt_d = cnt_q;
			else
				cnt_d = cnt_q + {{(`SDR_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Flags are live: no latching, so a vanished fault clears at once
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= {`SDR_CNT_W{1'b0}};
			pullup_en_o <= 1'b0;
			pulldown_en_o <= 1'b0;
			off_ol_flag_o <= 1'b0;
			short_flag_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pullup_en_o <= detect_on & ~svbb_en_i;
			pulldown_en_o <= ~fet_on_i & svbb_en_i;
			off_ol_flag_o <= detect_on & cmp_above_i;
			// Output held high against the pulldown long enough means a short
			short_flag_o <= pulldown_en_o & cmp_above_i & settled;
		end
	end

endmodule

// file: hdl/sdr_adc_seq.v
// Purpose: round-robin converter multiplexer and result storage
// Assumes: converter answers each start with one done pulse and data
// Notes: source index equals mux select code
`include "sdr_regs.vh"

module sdr_adc_seq (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Converter handshake
	input wire adc_done_i,
	input wire [`SDR_RES_W-1:0] adc_data_i,
	output reg [`SDR_SRC_W-1:0] mux_sel_o,
	output reg adc_start_o,
	// Stored results and new-current events
	output wire [`SDR_SRC_NUM*`SDR_RES_W-1:0] results_o,
	output reg [1:0] new_current_o
);

	localparam ST_IDLE = 2'd0;
	localparam ST_START = 2'd1;
	localparam ST_WAIT = 2'd2;

	reg [1:0] state_q;
	reg [1:0] state_d;
	wire done_now;

	assign done_now = (state_q == ST_WAIT) & adc_done_i;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always @* begin
		case (state_q)
			ST_IDLE: state_d = ST_START;
			ST_START: state_d = ST_WAIT;
			ST_WAIT: state_d = adc_done_i ? ST_IDLE : ST_WAIT;
			default: state_d = ST_IDLE;
		endcase
	end

	// Select changes only between conversions so a sample never mixes sources
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			mux_sel_o <= `SDR_SRC_I0;
			adc_start_o <= 1'b0;
			new_current_o <= 2'b00;
		end else begin
			state_q <= state_d;
			adc_start_o <= (state_d == ST_START);
			new_current_o[0] <= done_now & (mux_sel_o == `SDR_SRC_I0);
			new_current_o[1] <= done_now & (mux_sel_o == `SDR_SRC_I0 + 3'h1);
			if (done_now) begin
				if (mux_sel_o == `SDR_SRC_LAST)
					mux_sel_o <= `SDR_SRC_I0;
				else
					mux_sel_o <= mux_sel_o + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Result storage, one 10-bit word per source
	// ----------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < `SDR_SRC_NUM; k = k + 1) begin : g_res
			reg [`SDR_RES_W-1:0] res_q;
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					res_q <= `SDR_RES_RST;
				else if (done_now && (mux_sel_o == k[`SDR_SRC_W-1:0]))
					res_q <= adc_data_i;
			end
			assign results_o[k*`SDR_RES_W +: `SDR_RES_W] = res_q;
		end
	endgenerate

endmodule

// file: hdl/sdr_top.v
// Purpose: two-channel switch diagnostics readout with APB registers
// Assumes: all inputs synchronous to CLOCK_I; APB master holds requests
// Notes: one wait state on every APB access
//
// Design decisions made here: the APB slave port and the register offsets.
`include "sdr_regs.vh"

module sdr_top (
	// Clock and reset
	input wire CLOCK_I,
	input wire NRST_I,
	// APB slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [7:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	// Channel analog front end
	input wire [1:0] FET_ON_I,
	input wire [1:0] CMP_ABOVE_I,
	output wire [1:0] PULLUP_EN_O,
	output reg [3:0] PULLUP_STR_O,
	output wire [1:0] PULLDOWN_EN_O,
	output reg [1:0] SNS_RATIO_LOW_O,
	output reg [1:0] SNS_GAIN_X8_O,
	// Converter
	input wire ADC_DONE_I,
	input wire [9:0] ADC_DATA_I,
	output wire [2:0] ADC_MUX_SEL_O,
	output wire ADC_START_O,
	// Fault and interrupt
	output reg FAULT_INDICATOR_PIN_N_O,
	output reg IRQ_O
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	wire apb_acc;
	wire apb_done;
	wire apb_wr;
	wire apb_rd;
	reg [31:0] rdata_d;
	reg addr_ok_d;
	reg [1:0] fault_mask_q;
	reg [`SDR_INT_W-1:0] int_stat_q;
	reg [`SDR_INT_W-1:0] int_en_q;
	reg [`SDR_INT_W-1:0] int_set;
	wire [`SDR_INT_W-1:0] int_clr;
	wire [1:0] off_ol_flag;
	wire [1:0] short_flag;
	wire [1:0] new_current;
	wire [`SDR_SRC_NUM*`SDR_RES_W-1:0] results;
	wire [`SDR_CFG_W-1:0] cfg0;
	wire [`SDR_CFG_W-1:0] cfg1;
	wire [1:0] rdy;
	wire [1:0] ol_rise;
	wire [1:0] sh_rise;

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// Registered ready costs one wait state but keeps every output a flop
	assign apb_acc = PSEL_I & PENABLE_I;
	assign apb_done = apb_acc & PREADY_O;
	assign apb_wr = apb_done & PWRITE_I;
	assign apb_rd = apb_done & ~PWRITE_I;

	always @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= apb_acc & ~PREADY_O;
			if (apb_acc && !PREADY_O) begin
				PRDATA_O <= PWRITE_I ? 32'h00000000 : rdata_d;
				PSLVERR_O <= ~addr_ok_d;
			end else if (apb_done) begin
				PRDATA_O <= 32'h00000000;
				PSLVERR_O <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-channel configuration, ready flags and interrupt events
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : g_ch
			reg [`SDR_CFG_W-1:0] cfg_q;
			reg rdy_q;
			reg fresh_q;
			reg ol_prev_q;
			reg sh_prev_q;
			wire [7:0] cfg_addr;
			wire [7:0] res_addr;
			wire [`SDR_RES_W-1:0] cur;
			wire rd_hit;
			wire cap_hit;

			assign cfg_addr = c ? `SDR_ADDR_CFG1 : `SDR_ADDR_CFG0;
			assign res_addr = c ? `SDR_ADDR_I1 : `SDR_ADDR_I0;
			assign cur = results[c*`SDR_RES_W +: `SDR_RES_W];
			assign rd_hit = apb_rd & (PADDR_I == res_addr);
			assign cap_hit = apb_acc & ~PREADY_O & ~PWRITE_I & (PADDR_I == res_addr);
			assign rdy[c] = rdy_q;
			assign ol_rise[c] = off_ol_flag[c] & ~ol_prev_q;
			assign sh_rise[c] = short_flag[c] & ~sh_prev_q;

			// Configuration written by software, independent per channel
			always @(posedge CLOCK_I or negedge NRST_I) begin
				if (!NRST_I)
					cfg_q <= `SDR_CFG_RST;
				else if (apb_wr && (PADDR_I == cfg_addr))
					cfg_q <= PWDATA_I[`SDR_CFG_W-1:0];
			end

			// A result landing while a read is in flight keeps the flag set
			always @(posedge CLOCK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					rdy_q <= 1'b0;
					fresh_q <= 1'b0;
				end else begin
					if (new_current[c])
						rdy_q <= 1'b1;
					else if (rd_hit && !fresh_q)
						rdy_q <= 1'b0;
					if (cap_hit)
						fresh_q <= 1'b0;
					else if (new_current[c])
						fresh_q <= 1'b1;
				end
			end

			// Edge memory for the sticky interrupt events
			always @(posedge CLOCK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					ol_prev_q <= 1'b0;
					sh_prev_q <= 1'b0;
				end else begin
					ol_prev_q <= off_ol_flag[c];
					sh_prev_q <= short_flag[c];
				end
			end

			// Sense path controls
			always @(posedge CLOCK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					SNS_RATIO_LOW_O[c] <= 1'b0;
					SNS_GAIN_X8_O[c] <= 1'b0;
					PULLUP_STR_O[2*c +: 2] <= 2'h0;
				end else begin
					// Low ratio only takes hold while the load current is small
					SNS_RATIO_LOW_O[c] <= cfg_q[`SDR_CFG_OL_ON] &
						(cur < `SDR_OL_ON_LIMIT_CODE);
					SNS_GAIN_X8_O[c] <= cfg_q[`SDR_CFG_X8];
					PULLUP_STR_O[2*c +: 2] <= cfg_q[`SDR_CFG_PU_MSB:`SDR_CFG_PU_LSB];
				end
			end

			// Off-state diagnostic of this channel
			sdr_chan_diag u_diag (
				.clk_i(CLOCK_I),
				.rst_n_i(NRST_I),
				.fet_on_i(FET_ON_I[c]),
				.off_ol_en_i(cfg_q[`SDR_CFG_OFF_OL]),
				.svbb_en_i(cfg_q[`SDR_CFG_SVBB]),
				.cmp_above_i(CMP_ABOVE_I[c]),
				.pullup_en_o(PULLUP_EN_O[c]),
				.pulldown_en_o(PULLDOWN_EN_O[c]),
				.off_ol_flag_o(off_ol_flag[c]),
				.short_flag_o(short_flag[c])
			);
		end
	endgenerate

	assign cfg0 = g_ch[0].cfg_q;
	assign cfg1 = g_ch[1].cfg_q;

	// ----------------------------------------------------------------
	// Converter sequencer
	// ----------------------------------------------------------------
	sdr_adc_seq u_adc (
		.clk_i(CLOCK_I),
		.rst_n_i(NRST_I),
		.adc_done_i(ADC_DONE_I),
		.adc_data_i(ADC_DATA_I),
		.mux_sel_o(ADC_MUX_SEL_O),
		.adc_start_o(ADC_START_O),
		.results_o(results),
		.new_current_o(new_current)
	);

	// ----------------------------------------------------------------
	// Fault mask, fault pin and interrupts
	// ----------------------------------------------------------------
	assign int_clr = apb_wr && (PADDR_I == `SDR_ADDR_INT_CLR) ?
		PWDATA_I[`SDR_INT_W-1:0] : `SDR_INT_RST;

	always @* begin
		int_set = `SDR_INT_RST;
		int_set[`SDR_INT_OL_LSB +: 2] = ol_rise;
		int_set[`SDR_INT_SH_LSB +: 2] = sh_rise;
		int_set[`SDR_INT_RDY_LSB +: 2] = new_current;
	end

	// Set beats clear so an event in the clearing cycle is kept
	always @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			fault_mask_q <= `SDR_FMASK_RST;
			int_stat_q <= `SDR_INT_RST;
			int_en_q <= `SDR_INT_RST;
			IRQ_O <= 1'b0;
			FAULT_INDICATOR_PIN_N_O <= 1'b1;
		end else begin
			if (apb_wr && (PADDR_I == `SDR_ADDR_FMASK))
				fault_mask_q <= PWDATA_I[1:0];
			if (apb_wr && (PADDR_I == `SDR_ADDR_INT_EN))
				int_en_q <= PWDATA_I[`SDR_INT_W-1:0];
			int_stat_q <= (int_stat_q & ~int_clr) | int_set;
			IRQ_O <= |(int_stat_q & int_en_q);
			// Pin follows the live open-load flags only, not the short flags; masked channels never pull it low
			FAULT_INDICATOR_PIN_N_O <= ~|(off_ol_flag & ~fault_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		addr_ok_d = 1'b1;
		case (PADDR_I)
			`SDR_ADDR_CFG0: rdata_d[`SDR_CFG_W-1:0] = cfg0;
			`SDR_ADDR_CFG1: rdata_d[`SDR_CFG_W-1:0] = cfg1;
			`SDR_ADDR_FMASK: rdata_d[1:0] = fault_mask_q;
			`SDR_ADDR_STAT0: begin
				rdata_d[`SDR_STAT_OFF_OL] = off_ol_flag[0];
				rdata_d[`SDR_STAT_SHORT] = short_flag[0];
				rdata_d[`SDR_STAT_RDY] = rdy[0];
			end
			`SDR_ADDR_STAT1: begin
				rdata_d[`SDR_STAT_OFF_OL] = off_ol_flag[1];
				rdata_d[`SDR_STAT_SHORT] = short_flag[1];
				rdata_d[`SDR_STAT_RDY] = rdy[1];
			end
			`SDR_ADDR_I0: begin
				rdata_d[`SDR_RES_W-1:0] = results[0*`SDR_RES_W +: `SDR_RES_W];
				rdata_d[`SDR_RES_RDY_BIT] = rdy[0];
			end
			`SDR_ADDR_I1: begin
				rdata_d[`SDR_RES_W-1:0] = results[1*`SDR_RES_W +: `SDR_RES_W];
				rdata_d[`SDR_RES_RDY_BIT] = rdy[1];
			end
			`SDR_ADDR_V0: rdata_d[`SDR_RES_W-1:0] = results[2*`SDR_RES_W +: `SDR_RES_W];
			`SDR_ADDR_V1: rdata_d[`SDR_RES_W-1:0] = results[3*`SDR_RES_W +: `SDR_RES_W];
			`SDR_ADDR_T0: rdata_d[`SDR_RES_W-1:0] = results[4*`SDR_RES_W +: `SDR_RES_W];
			`SDR_ADDR_T1: rdata_d[`SDR_RES_W-1:0] = results[5*`SDR_RES_W +: `SDR_RES_W];
			`SDR_ADDR_VBB: rdata_d[`SDR_RES_W-1:0] = results[6*`SDR_RES_W +: `SDR_RES_W];
			`SDR_ADDR_INT_STAT: rdata_d[`SDR_INT_W-1:0] = int_stat_q;
			`SDR_ADDR_INT_CLR: rdata_d = 32'h00000000;
			`SDR_ADDR_INT_EN: rdata_d[`SDR_INT_W-1:0] = int_en_q;
			default: addr_ok_d = 1'b0;
		endcase
	end

endmodule

// file: test/sdr_checker.sv
// Purpose: port-level checks of sdr_top
// Assumes: one clock domain, reset asynchronous and low
// Notes: attached to every sdr_top by bind
module sdr_checker (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	// APB
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Front end and converter
	input wire logic [1:0] FET_ON_I,
	input wire logic [1:0] CMP_ABOVE_I,
	input wire logic [1:0] PULLUP_EN_O,
	input wire logic [1:0] PULLDOWN_EN_O,
	input wire logic ADC_DONE_I,
	input wire logic [2:0] ADC_MUX_SEL_O,
	input wire logic ADC_START_O,
	input wire logic FAULT_INDICATOR_PIN_N_O
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Steps of a transfer
	// ----------------------------------------
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!NRST_I);
	sequence apb_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence apb_access;
		PSEL_I && PENABLE_I;
	endsequence
	sequence cmp_low;
		(CMP_ABOVE_I == 2'h0) [*2];
	endsequence
	// One wait state, answer a single cycle wide
	ready_timing_a: assert property (apb_setup ##1 apb_access |-> !PREADY_O ##1 PREADY_O)
		else $error("ready not at second access cycle");
	ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside answer");
	// Comparator drive only on an off FET; never both sources at once
	pullup_fet_off_a: assert property ((PULLUP_EN_O & $past(FET_ON_I)) == 2'h0)
		else $error("pullup on with FET on");
	pulldown_fet_off_a: assert property ((PULLDOWN_EN_O & $past(FET_ON_I)) == 2'h0)
		else $error("pulldown on with FET on");
	drive_exclusive_a: assert property ((PULLUP_EN_O & PULLDOWN_EN_O) == 2'h0)
		else $error("pullup and pulldown together");
	// Fault pin follows the live comparator with two register stages
	fault_cause_a: assert property ($fell(FAULT_INDICATOR_PIN_N_O) |-> $past(CMP_ABOVE_I, 2) != 2'h0)
		else $error("fault without comparator");
	fault_clear_a: assert property (cmp_low |=> FAULT_INDICATOR_PIN_N_O)
		else $error("fault kept after comparator low");
	// Converter sweep
	start_pulse_a: assert property (ADC_START_O |=> !ADC_START_O)
		else $error("start longer than one cycle");
	restart_a: assert property (ADC_DONE_I |-> ##2 ADC_START_O)
		else $error("no start after done");
	mux_step_a: assert property (ADC_DONE_I |=> ADC_MUX_SEL_O == (($past(ADC_MUX_SEL_O) == 3'h6) ?
		3'h0 : $past(ADC_MUX_SEL_O) + 3'h1))
		else $error("mux did not advance");
endmodule

bind sdr_top sdr_checker i_sdr_checker (
	.CLOCK_I(CLOCK_I),
	.NRST_I(NRST_I),
	.PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I),
	.PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O),
	.FET_ON_I(FET_ON_I),
	.CMP_ABOVE_I(CMP_ABOVE_I),
	.PULLUP_EN_O(PULLUP_EN_O),
	.PULLDOWN_EN_O(PULLDOWN_EN_O),
	.ADC_DONE_I(ADC_DONE_I),
	.ADC_MUX_SEL_O(ADC_MUX_SEL_O),
	.ADC_START_O(ADC_START_O),
	.FAULT_INDICATOR_PIN_N_O(FAULT_INDICATOR_PIN_N_O)
);

// file: test/sdr_adc_model.sv
// Purpose: converter model answering each start
// Assumes: data is base plus source index
// Notes: hold stalls the answer as long as wanted
module sdr_adc_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Converter handshake
	input wire logic start_i,
	input wire logic [2:0] sel_i,
	output logic done_o,
	output logic [9:0] data_o,
	// Bench control
	input wire logic hold_i,
	input wire logic [9:0] base_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q;
	logic [1:0] cnt_q;
	logic [9:0] val_q;
	// Four cycles per conversion; data toggles outside done so stale values never pass
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			cnt_q <= 2'h0;
			val_q <= 10'h000;
			done_o <= 1'b0;
			data_o <= 10'h3ff;
		end else begin
			done_o <= 1'b0;
			data_o <= ~data_o;
			if (start_i) begin
				busy_q <= 1'b1;
				cnt_q <= 2'h0;
				val_q <= base_i + {7'h00, sel_i};
			end else if (busy_q && !hold_i) begin
				cnt_q <= cnt_q + 2'h1;
				if (cnt_q == 2'h3) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
					data_o <= val_q;
				end
			end
		end
	end
endmodule

// file: test/tb.sv
// Purpose: register-level test of sdr_top
// Assumes: 40 MHz clock, converter model on the far side
// Notes: status reads mask the ready bit where it races
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic [1:0] fet = 2'h0;
	logic [1:0] cmp = 2'h0;
	logic hold = 1'b0;
	logic [9:0] base = 10'h012;
	logic [31:0] prd;
	logic prdy, perr, done, start, fltn, irq;
	logic [1:0] pu, pd, rlow, gx8;
	logic [3:0] pstr;
	logic [9:0] adat;
	logic [2:0] msel;
	logic [31:0] rv;
	logic re;
	logic [9:0] smp [3];
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	sdr_top i_sdr_top (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
		.PSLVERR_O(perr), .FET_ON_I(fet), .CMP_ABOVE_I(cmp), .PULLUP_EN_O(pu),
		.PULLUP_STR_O(pstr), .PULLDOWN_EN_O(pd), .SNS_RATIO_LOW_O(rlow), .SNS_GAIN_X8_O(gx8),
		.ADC_DONE_I(done), .ADC_DATA_I(adat), .ADC_MUX_SEL_O(msel), .ADC_START_O(start),
		.FAULT_INDICATOR_PIN_N_O(fltn), .IRQ_O(irq));
	sdr_adc_model i_sdr_adc_model (.clk_i(clk), .rst_n_i(nrst), .start_i(start), .sel_i(msel),
		.done_o(done), .data_o(adat), .hold_i(hold), .base_i(base));
	// ----------------------------------------
	// Clock, timeout, report
	// ----------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// ----------------------------------------
	// APB master: hold request until ready
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Look mid-cycle: the answer then stands unchanged up to the completing edge
		do @(negedge clk); while (prdy !== 1'b1);
		rv = prd;
		re = perr;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Median of three samples rejects a single outlier
	function automatic logic [9:0] med3(input logic [9:0] a, input logic [9:0] b,
		input logic [9:0] c);
		return (a > b) ? ((b > c) ? b : ((a > c) ? c : a)) : ((a > c) ? a : ((b > c) ? c : b));
	endfunction
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm,
		input logic [31:0] m = 32'hffffffff);
		apb(1'b0, a, 32'h0);
		chk_reg(nm, exp, rv & m);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		wt(5);
		nrst <= 1'b1;
		rd(8'h00, 32'h0, "cfg0");
		rd(8'h08, 32'h0, "fmask");
		rd(8'h38, 32'h0, "int_en");
		rd(8'h3c, 32'h0, "unmapped");
		chk_pin("slverr", 4'h1, {3'h0, re});
		// Open load on channel 0 only
		cmp <= 2'h1;
		wr(8'h00, 32'h31);
		wt(5);
		chk_pin("pullup", 4'h1, {2'h0, pu});
		chk_pin("pu_str", 4'h3, pstr);
		chk_pin("fault", 4'h0, {3'h0, fltn});
		rd(8'h0c, 32'h1, "stat0", 32'h3);
		rd(8'h10, 32'h0, "stat1", 32'h3);
		wr(8'h08, 32'h1);
		wt(3);
		chk_pin("fault_masked", 4'h1, {3'h0, fltn});
		wr(8'h08, 32'h0);
		cmp <= 2'h0;
		wt(4);
		chk_pin("fault_live", 4'h1, {3'h0, fltn});
		rd(8'h0c, 32'h0, "stat0_live", 32'h3);
		// Short check while output stays high
		cmp <= 2'h1;
		wr(8'h00, 32'h33);
		wt(3);
		chk_pin("pulldown", 4'h1, {2'h0, pd});
		chk_pin("pullup_off", 4'h0, {2'h0, pu});
		wt(90);
		rd(8'h0c, 32'h3, "stat0_short", 32'h3);
		// Interrupt: masked, enabled, cleared
		rd(8'h30, 32'h35, "int_stat");
		chk_pin("irq_masked", 4'h0, {3'h0, irq});
		wr(8'h38, 32'h4);
		wt(2);
		chk_pin("irq_on", 4'h1, {3'h0, irq});
		wr(8'h34, 32'h4);
		wt(2);
		chk_pin("irq_off", 4'h0, {3'h0, irq});
		rd(8'h30, 32'h31, "int_clr");
		fet <= 2'h1;
		wt(3);
		chk_pin("drive_fet_on", 4'h0, {pu, pd});
		// Sense scaling
		fet <= 2'h0;
		cmp <= 2'h0;
		wr(8'h00, 32'h04);
		wr(8'h04, 32'h08);
		wt(3);
		chk_pin("ratio_low", 4'h1, {2'h0, rlow});
		chk_pin("gain_x8", 4'h2, {2'h0, gx8});
		// Results with the converter stalled
		hold <= 1'b1;
		wt(20);
		rd(8'h14, 32'h8012, "cur0");
		rd(8'h14, 32'h0012, "cur0_again");
		rd(8'h18, 32'h8013, "cur1");
		for (int s = 2; s < 7; s++) begin
			rd(8'h14 + 8'(4 * s), 32'h12 + 32'(s), "vt_res");
		end
		// Large current: low ratio must drop
		base <= 10'h100;
		hold <= 1'b0;
		wt(120);
		hold <= 1'b1;
		wt(20);
		chk_pin("ratio_high", 4'h0, {2'h0, rlow});
		rd(8'h14, 32'h8100, "cur0_new");
		// Host filtering: several samples, median taken as the estimate
		for (int s = 0; s < 3; s++) begin
			apb(1'b0, 8'h18, 32'h0);
			smp[s] = rv[9:0];
		end
		chk_reg("cur1_median", 32'h101, {22'h0, med3(smp[0], smp[1], smp[2])});
		summarize();
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
endmodule
